// ### verilog/cpr_pkg.sv
// package: packet words, commands and timing for the reconfiguration host
`default_nettype none
package cpr_pkg;
  localparam int WORD_W = 32;
  localparam int CNT_W = 24;
  // packet header words
  localparam logic [31:0] SYNC_WORD = 32'haa995566;
  localparam logic [31:0] HDR_CMD_1 = 32'h30008001;
  localparam logic [31:0] HDR_FLEN_1 = 32'h30016001;
  localparam logic [31:0] HDR_FAR_1 = 32'h30002001;
  localparam logic [31:0] HDR_FDATA_0 = 32'h30004000;
  localparam logic [31:0] HDR_TYPE2_BASE = 32'h50000000;
  localparam logic [31:0] HDR_FDATA_52 = 32'h30004034;
  localparam logic [31:0] HDR_CTRL_1 = 32'h3000a001;
  localparam logic [31:0] HDR_CRC_1 = 32'h30000001;
  localparam logic [31:0] NOOP_WORD = 32'h20000000;
  // command codes
  localparam logic [31:0] CMD_WRITE_CONFIG_CMD = 32'h00000001;
  localparam logic [31:0] CMD_LAST_FRAME_CMD = 32'h00000003;
  localparam logic [31:0] CMD_START = 32'h00000005;
  localparam logic [31:0] CMD_RESET_CRC_CMD = 32'h00000007;
  localparam logic [31:0] CMD_SWITCH = 32'h00000009;
  localparam logic [31:0] CMD_RESTORE = 32'h0000000a;
  localparam logic [31:0] CMD_SHUTDOWN = 32'h0000000b;
  localparam logic [31:0] CMD_DESYNC = 32'h0000000d;
  localparam logic [31:0] FRAME_PAD_WORDS = 32'd52;
  localparam int NOOP_COUNT = 2;
  // jtag shutdown sequence
  localparam logic [5:0] JTAG_SHUTDOWN_INSTR = 6'h0d;
  localparam int JTAG_IR_LEN = 6;
  localparam int JTAG_TLR_CLOCKS = 5;
  localparam int JTAG_RTI_CLOCKS = 12;
  localparam int JTAG_SEQ_LEN = JTAG_TLR_CLOCKS + 1 + 2 + 2 + JTAG_IR_LEN + 1 + JTAG_RTI_CLOCKS;
  // host sequencer states
  typedef enum logic [4:0] {
    CPR_IDLE = 5'h00, CPR_SYNC = 5'h01, CPR_SHUT = 5'h02, CPR_RESET_CRC_CMD = 5'h03,
    CPR_FLEN = 5'h04, CPR_SWITCH = 5'h05, CPR_FAR = 5'h06, CPR_WRITE_CONFIG_CMD = 5'h07,
    CPR_FHDR0 = 5'h08, CPR_FHDR2 = 5'h09, CPR_FDATA = 5'h0a, CPR_ACRC = 5'h0b,
    CPR_REST = 5'h0c, CPR_LAST_FRAME_CMD = 5'h0d, CPR_FRZ_WRITE_CONFIG_CMD = 5'h0e, CPR_FRZ_FAR = 5'h0f,
    CPR_FRZ_HDR = 5'h10, CPR_FRZ_DATA = 5'h11, CPR_FRZ_ACRC = 5'h12, CPR_START = 5'h13,
    CPR_CTRL = 5'h14, CPR_CRC = 5'h15, CPR_DESYNC = 5'h16, CPR_NOOP = 5'h17,
    CPR_WAIT_DONE = 5'h18, CPR_JTAG = 5'h19
  } cpr_state_t;
endpackage : cpr_pkg
`default_nettype wire

// ### verilog/cpr_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module cpr_pin_sync (
  // clock, reset and enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // pin
  input wire logic pin_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // only accept a level once the two later stages agree
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      level_o <= 1'b0;
    else if (ce_i && (s2_reg == s3_reg))
      level_o <= s3_reg;
  end
endmodule // cpr_pin_sync
`default_nettype wire

// ### verilog/cpr_toggle_xfer.sv
// toggle event crossing into a destination clock domain
`timescale 1ns/1ns
`default_nettype none
module cpr_toggle_xfer (
  // source side
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic src_ce_i,
  input wire logic src_pulse_i,
  // destination side
  input wire logic dst_clk_i,
  input wire logic dst_rst_n_i,
  output logic dst_pulse_o
);
  logic tog_reg;
  logic d1_reg;
  logic d2_reg;
  logic d3_reg;
  always_ff @(posedge src_clk_i)
  begin
    if (!src_rst_n_i)
      tog_reg <= 1'b0;
    else if (src_ce_i && src_pulse_i)
      tog_reg <= ~tog_reg;
  end
  always_ff @(posedge dst_clk_i)
  begin
    if (!dst_rst_n_i)
    begin
      d1_reg <= 1'b0;
      d2_reg <= 1'b0;
      d3_reg <= 1'b0;
    end
    else
    begin
      d1_reg <= tog_reg;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end
  assign dst_pulse_o = d2_reg ^ d3_reg;
endmodule // cpr_toggle_xfer
`default_nettype wire

// ### verilog/cpr_host.sv
// reconfiguration host: parallel packet sequencer and jtag shutdown engine
`timescale 1ns/1ns
`default_nettype none
//
// Behaviour
// - bulk frames: zero-count header, then type-2 count
// - supply auto crc word after frame data
// - send restore-initial-state command packet
// - then send last-frame command
// - optional freeze: write_config_cmd, address, 52-word frame
// - start command begins device startup
// - write control word after start
// - write final crc word
// - keep clocking until done goes high or DONE_TIMEOUT clock cycles pass
// - parallel shutdown command right after sync
// - jtag: twelve clocks in run-test/idle
// - five tms highs, then to shift-ir
// - six-bit instruction lsb first, msb exits
// - reset crc before shutdown completes
// - shutdown left only through startup
// - shutdown variant: shutdown before crc reset
// - switch only in master; length minus one
module cpr_host
  import cpr_pkg::*;
#(
  parameter int DONE_TIMEOUT = 65536
) (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // user command
  input wire logic go_i,
  input wire logic shutdown_mode_i,
  input wire logic jtag_shutdown_i,
  input wire logic freeze_i,
  input wire logic master_mode_i,
  input wire logic [CNT_W-1:0] frame_len_i,
  input wire logic [CNT_W-1:0] frame_count_i,
  input wire logic [cpr_pkg::WORD_W-1:0] freeze_far_i,
  input wire logic [cpr_pkg::WORD_W-1:0] ctrl_word_i,
  input wire logic [cpr_pkg::WORD_W-1:0] crc_word_i,
  input wire logic [cpr_pkg::WORD_W-1:0] auto_crc_i,
  output logic busy_o,
  output logic finished_o,
  output logic timeout_o,
  // frame data stream
  input wire logic [cpr_pkg::WORD_W-1:0] fdata_i,
  input wire logic fdata_valid_i,
  output logic fdata_ready_o,
  // parallel packet port
  output logic [cpr_pkg::WORD_W-1:0] cfg_data_o,
  output logic cfg_write_o,
  output logic config_clock_o,
  input wire logic done_i,
  // jtag port
  input wire logic tck_i,
  input wire logic tck_rst_n_i,
  output logic tms_o,
  output logic tdi_o,
  output logic jtag_done_o
);
  ////////////////////////////////////////////////////////////////////
  cpr_state_t state_reg;
  cpr_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] total_words;
  logic [31:0] wait_reg;
  logic clk_div_reg;
  logic done_s;
  logic word_step;
  logic jtag_start;
  logic jtag_start_tck;
  logic jtag_end_tck;
  logic jtag_end;
  logic [4:0] jcnt_reg;
  logic jrun_reg;

  // device samples on the rising config_clock edge, so words move on the falling one
  assign word_step = ce_i && clk_div_reg;
  // data words plus one pad frame
  assign total_words = CNT_W'((frame_count_i + CNT_W'(1)) * frame_len_i);

  cpr_pin_sync u_done_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(done_i),
    .level_o(done_s)
  );

  ////////////////////////////////////////////////////////////////////
  // config clock divider
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      clk_div_reg <= 1'b0;
    else if (ce_i)
      clk_div_reg <= ~clk_div_reg;
  end
  // keeps running while waiting for done
  assign config_clock_o = clk_div_reg && busy_o && (state_reg != CPR_JTAG);

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CPR_IDLE:
        if (go_i)
          state_next = jtag_shutdown_i ? CPR_JTAG : CPR_SYNC;
      CPR_SYNC:
        if (cnt_reg == CNT_W'(1))
          state_next = shutdown_mode_i ? CPR_SHUT : CPR_RESET_CRC_CMD;
      CPR_SHUT:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_RESET_CRC_CMD;
      CPR_RESET_CRC_CMD:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_FLEN;
      CPR_FLEN:
        if (cnt_reg == CNT_W'(1))
          state_next = master_mode_i ? CPR_SWITCH : CPR_FAR;
      CPR_SWITCH:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_FAR;
      CPR_FAR:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_WRITE_CONFIG_CMD;
      CPR_WRITE_CONFIG_CMD:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_FHDR0;
      CPR_FHDR0:
        state_next = CPR_FHDR2;
      CPR_FHDR2:
        state_next = CPR_FDATA;
      CPR_FDATA:
        if (fdata_valid_i && cnt_reg == CNT_W'(1))
          state_next = CPR_ACRC;
      CPR_ACRC:
        state_next = CPR_REST;
      CPR_REST:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_LAST_FRAME_CMD;
      CPR_LAST_FRAME_CMD:
        if (cnt_reg == CNT_W'(1))
          state_next = freeze_i ? CPR_FRZ_WRITE_CONFIG_CMD : CPR_START;
      CPR_FRZ_WRITE_CONFIG_CMD:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_FRZ_FAR;
      CPR_FRZ_FAR:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_FRZ_HDR;
      CPR_FRZ_HDR:
        state_next = CPR_FRZ_DATA;
      CPR_FRZ_DATA:
        if (fdata_valid_i && cnt_reg == CNT_W'(1))
          state_next = CPR_FRZ_ACRC;
      CPR_FRZ_ACRC:
        state_next = CPR_START;
      CPR_START:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_CTRL;
      CPR_CTRL:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_CRC;
      CPR_CRC:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_DESYNC;
      CPR_DESYNC:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_NOOP;
      CPR_NOOP:
        if (cnt_reg == CNT_W'(1))
          state_next = CPR_WAIT_DONE;
      CPR_WAIT_DONE:
        // leave only while config_clock is high, so the last noop has been clocked in
        if (clk_div_reg && (done_s || wait_reg >= 32'(DONE_TIMEOUT)))
          state_next = CPR_IDLE;
      CPR_JTAG:
        if (jtag_end)
          state_next = CPR_IDLE;
      default:
        state_next = CPR_IDLE;
    endcase
  end

  // state and word counter advance one word per config clock
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      state_reg <= CPR_IDLE;
    else if (ce_i && (state_reg == CPR_IDLE || state_reg == CPR_JTAG ||
                      state_reg == CPR_WAIT_DONE || word_step))
      state_reg <= state_next;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      cnt_reg <= CNT_W'(0);
    else if (ce_i && state_next != state_reg && (word_step || state_reg == CPR_IDLE))
    begin
      case (state_next)
        CPR_FDATA: cnt_reg <= total_words;
        CPR_FRZ_DATA: cnt_reg <= CNT_W'(FRAME_PAD_WORDS);
        CPR_SYNC, CPR_NOOP: cnt_reg <= CNT_W'(NOOP_COUNT);
        default: cnt_reg <= CNT_W'(2);
      endcase
    end
    else if (word_step && cnt_reg != CNT_W'(0) &&
             !((state_reg == CPR_FDATA || state_reg == CPR_FRZ_DATA) && !fdata_valid_i))
      cnt_reg <= cnt_reg - CNT_W'(1);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      wait_reg <= 32'h00000000;
    else if (ce_i)
      wait_reg <= (state_reg == CPR_WAIT_DONE) ? wait_reg + 32'h00000001 : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////
  // word generation: two-word states send header then payload, except sync (noop, then sync word) and noop (two noops)
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cfg_data_o <= 32'h00000000;
      cfg_write_o <= 1'b0;
    end
    else if (word_step)
    begin
      cfg_write_o <= 1'b1;
      case (state_reg)
        CPR_SYNC: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? NOOP_WORD : SYNC_WORD;
        CPR_SHUT: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_SHUTDOWN;
        CPR_RESET_CRC_CMD: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_RESET_CRC_CMD;
        CPR_FLEN: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_FLEN_1 :
                                32'(frame_len_i - CNT_W'(1));
        CPR_SWITCH: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_SWITCH;
        CPR_FAR: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_FAR_1 : 32'h00000000;
        CPR_WRITE_CONFIG_CMD, CPR_FRZ_WRITE_CONFIG_CMD: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_WRITE_CONFIG_CMD;
        CPR_FHDR0: cfg_data_o <= HDR_FDATA_0;
        CPR_FHDR2: cfg_data_o <= HDR_TYPE2_BASE | 32'(total_words);
        CPR_FDATA, CPR_FRZ_DATA:
        begin
          cfg_data_o <= fdata_i;
          cfg_write_o <= fdata_valid_i;
        end
        CPR_ACRC, CPR_FRZ_ACRC: cfg_data_o <= auto_crc_i;
        CPR_REST: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_RESTORE;
        CPR_LAST_FRAME_CMD: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_LAST_FRAME_CMD;
        CPR_FRZ_FAR: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_FAR_1 : freeze_far_i;
        CPR_FRZ_HDR: cfg_data_o <= HDR_FDATA_52;
        CPR_START: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_START;
        CPR_CTRL: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CTRL_1 : ctrl_word_i;
        CPR_CRC: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CRC_1 : crc_word_i;
        CPR_DESYNC: cfg_data_o <= (cnt_reg == CNT_W'(2)) ? HDR_CMD_1 : CMD_DESYNC;
        CPR_NOOP: cfg_data_o <= NOOP_WORD;
        default: cfg_write_o <= 1'b0;
      endcase
    end
  end

  assign fdata_ready_o = word_step && (state_reg == CPR_FDATA || state_reg == CPR_FRZ_DATA);
  assign busy_o = (state_reg != CPR_IDLE);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      finished_o <= 1'b0;
      timeout_o <= 1'b0;
    end
    else if (ce_i)
    begin
      finished_o <= (state_reg != CPR_IDLE) && (state_next == CPR_IDLE);
      timeout_o <= (state_reg == CPR_WAIT_DONE) && (state_next == CPR_IDLE) && !done_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // jtag shutdown runs in the tck domain
  assign jtag_start = go_i && jtag_shutdown_i && (state_reg == CPR_IDLE);

  cpr_toggle_xfer u_start_xfer (
    .src_clk_i(clock_i),
    .src_rst_n_i(rst_n_i),
    .src_ce_i(ce_i),
    .src_pulse_i(jtag_start),
    .dst_clk_i(tck_i),
    .dst_rst_n_i(tck_rst_n_i),
    .dst_pulse_o(jtag_start_tck)
  );

  cpr_toggle_xfer u_end_xfer (
    .src_clk_i(tck_i),
    .src_rst_n_i(tck_rst_n_i),
    .src_ce_i(1'b1),
    .src_pulse_i(jtag_end_tck),
    .dst_clk_i(clock_i),
    .dst_rst_n_i(rst_n_i),
    .dst_pulse_o(jtag_end)
  );

  assign jtag_end_tck = jrun_reg && (jcnt_reg == 5'(JTAG_SEQ_LEN - 1));

  always_ff @(posedge tck_i)
  begin
    if (!tck_rst_n_i)
    begin
      jrun_reg <= 1'b0;
      jcnt_reg <= 5'h00;
    end
    else if (jtag_start_tck && !jrun_reg)
    begin
      jrun_reg <= 1'b1;
      jcnt_reg <= 5'h00;
    end
    else if (jrun_reg)
    begin
      jrun_reg <= !jtag_end_tck;
      jcnt_reg <= jcnt_reg + 5'h01;
    end
  end

  // tms/tdi change on the falling tck edge for the tap to sample on rise
  always_ff @(negedge tck_i)
  begin
    if (!tck_rst_n_i)
    begin
      tms_o <= 1'b1;
      tdi_o <= 1'b0;
    end
    else if (!jrun_reg)
    begin
      tms_o <= 1'b1;
      tdi_o <= 1'b0;
    end
    else if (jcnt_reg < 5'(JTAG_TLR_CLOCKS))
      tms_o <= 1'b1;
    else if (jcnt_reg < 5'(JTAG_TLR_CLOCKS + 1))
      tms_o <= 1'b0;
    else if (jcnt_reg < 5'(JTAG_TLR_CLOCKS + 3))
      tms_o <= 1'b1;
    else if (jcnt_reg < 5'(JTAG_TLR_CLOCKS + 5))
      tms_o <= 1'b0;
    else if (jcnt_reg < 5'(JTAG_TLR_CLOCKS + 5 + JTAG_IR_LEN))
    begin
      // last instruction bit leaves shift-ir
      tdi_o <= JTAG_SHUTDOWN_INSTR[3'(jcnt_reg - 5'(JTAG_TLR_CLOCKS + 5))];
      tms_o <= (jcnt_reg == 5'(JTAG_TLR_CLOCKS + 4 + JTAG_IR_LEN));
    end
    else if (jcnt_reg < 5'(JTAG_TLR_CLOCKS + 6 + JTAG_IR_LEN))
      tms_o <= 1'b1;
    else
      tms_o <= 1'b0;
  end

  assign jtag_done_o = jrun_reg;
endmodule // cpr_host
`default_nettype wire

// ### bench/cpr_host_props.sv
// checker: port-level properties of the reconfiguration host
`timescale 1ns/1ns
`default_nettype none
module cpr_host_props (
  // main domain
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic go_i,
  input wire logic busy_o,
  input wire logic finished_o,
  input wire logic timeout_o,
  input wire logic fdata_ready_o,
  // packet port
  input wire logic [31:0] cfg_data_o,
  input wire logic cfg_write_o,
  input wire logic config_clock_o,
  // jtag domain
  input wire logic tck_i,
  input wire logic tck_rst_n_i,
  input wire logic tms_o,
  input wire logic jtag_done_o
);
  property p_go_busy;
    @(posedge clock_i) disable iff (!rst_n_i) !busy_o && go_i && ce_i |=> busy_o;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("go did not start a sequence");
  property p_word_hold;
    @(posedge clock_i) disable iff (!rst_n_i) cfg_write_o && $changed(cfg_data_o) |=> $stable(cfg_data_o);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("packet word held one cycle");
  property p_clk_idle;
    @(posedge clock_i) disable iff (!rst_n_i) !busy_o |-> !config_clock_o;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("config clock while idle");
  property p_write_idle;
    @(posedge clock_i) disable iff (!rst_n_i) !busy_o [*3] |-> !cfg_write_o;
  endproperty
  a_write_idle: assert property (p_write_idle) else $error("write strobe while idle");
  property p_ready_busy;
    @(posedge clock_i) disable iff (!rst_n_i) fdata_ready_o |-> busy_o && config_clock_o;
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("frame data taken outside load");
  property p_fin_once;
    @(posedge clock_i) disable iff (!rst_n_i) finished_o |=> !finished_o;
  endproperty
  a_fin_once: assert property (p_fin_once) else $error("finished longer than one cycle");
  property p_fin_idle;
    @(posedge clock_i) disable iff (!rst_n_i) finished_o |-> !busy_o;
  endproperty
  a_fin_idle: assert property (p_fin_idle) else $error("finished while busy");
  property p_timeout;
    @(posedge clock_i) disable iff (!rst_n_i) timeout_o |-> ##[0:2] !busy_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("busy after done timeout");
  property p_jtag_end;
    @(posedge tck_i) disable iff (!tck_rst_n_i) $fell(jtag_done_o) |-> !$past(tms_o) && !$past(tms_o, 6);
  endproperty
  a_jtag_end: assert property (p_jtag_end) else $error("jtag ended outside idle run");
  c_go: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(busy_o));
  c_timeout: cover property (@(posedge clock_i) disable iff (!rst_n_i) timeout_o);
  c_jtag: cover property (@(posedge tck_i) disable iff (!tck_rst_n_i) $fell(jtag_done_o));
endmodule // cpr_host_props
`default_nettype wire

// ### bench/cpr_dev_model.sv
// device-side model: packet capture, shutdown, startup and tap recording
`timescale 1ns/1ns
`default_nettype none
module cpr_dev_model
  import cpr_pkg::*;
(
  // packet port
  input wire logic config_clock_i,
  input wire logic cfg_write_i,
  input wire logic [31:0] cfg_data_i,
  input wire logic [31:0] exp_crc_i,
  output logic done_o,
  // jtag
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i
);
  logic [31:0] words[$];
  logic [1:0] tapq[$];
  logic [31:0] last;
  logic started;
  logic crc_err;
  int flush;
  int su;
  initial
  begin
    done_o = 1'b1;
    last = 32'h0;
    started = 1'b0;
    crc_err = 1'b0;
    flush = -1;
    su = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // a new sync restarts the load, no program pulse needed
  always @(posedge config_clock_i)
  begin
    if (cfg_write_i)
    begin
      words.push_back(cfg_data_i); // every written word is queued in arrival order
      if (cfg_data_i == SYNC_WORD)
        flush <= -1;
      if (last == HDR_CMD_1 && cfg_data_i == CMD_SHUTDOWN)
      begin
        done_o <= 1'b0;
        started <= 1'b0;
        su <= 0;
      end
      if (last == HDR_CMD_1 && cfg_data_i == CMD_START)
        started <= 1'b1;
      if (last == HDR_CMD_1 && cfg_data_i == CMD_RESET_CRC_CMD)
        crc_err <= 1'b0;
      if (last == HDR_CRC_1)
        crc_err <= (cfg_data_i !== exp_crc_i);
      if (last == HDR_CMD_1 && cfg_data_i == CMD_DESYNC)
        flush <= 0;
      else if (flush >= 0 && cfg_data_i == NOOP_WORD)
        flush <= flush + 1;
      last <= cfg_data_i;
    end
    // startup needs further clock pulses and no crc error
    if (flush >= 2 && started && !crc_err && !done_o)
    begin
      su <= su + 1;
      if (su == 3)
        done_o <= 1'b1;
    end
  end
  // tms and tdi taken at rising tck, as a tap would
  always @(posedge tck_i)
    tapq.push_back({tms_i, tdi_i});
endmodule // cpr_dev_model
`default_nettype wire

// ### bench/testbench.sv
// bench: reconfiguration host driven against the device model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cpr_pkg::*;
  localparam logic [28:0] ETMS = 29'b11111_0_11_00_00000_1_1_000000000000;
  logic clock_i, rst_n_i, ce_i, go_i, shutdown_mode_i, jtag_shutdown_i, freeze_i, master_mode_i;
  logic [CNT_W-1:0] frame_len_i, frame_count_i;
  logic [31:0] freeze_far_i, ctrl_word_i, crc_word_i, auto_crc_i, fdata_i, cfg_data_o, dcrc;
  logic fdata_valid_i, fdata_ready_o, cfg_write_o, config_clock_o, done_i;
  logic busy_o, finished_o, timeout_o, tck_i, tck_rst_n_i, tms_o, tdi_o, jtag_done_o;
  logic [32:0] exp[$];
  logic [1:0] gap;
  int fails, compares, cyc;

  cpr_host #(.DONE_TIMEOUT(64)) cpr_host_i (.*);
  cpr_dev_model cpr_dev_model_i (.config_clock_i(config_clock_o), .cfg_write_i(cfg_write_o),
    .cfg_data_i(cfg_data_o), .exp_crc_i(dcrc), .done_o(done_i), .tck_i(tck_i),
    .tms_i(tms_o), .tdi_i(tdi_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic put(input logic [31:0] w, input logic any = 1'b0);
    exp.push_back({any, w});
  endtask
  task automatic go_wait(output logic fin, output logic to);
    int n;
    n = 0;
    fin = 1'b0;
    to = 1'b0;
    @(posedge clock_i);
    go_i <= 1'b1;
    @(posedge clock_i);
    go_i <= 1'b0;
    while (!fin && !to && n < 20000)
    begin
      @(negedge clock_i);
      fin = finished_o;
      to = timeout_o;
      n++;
    end
  endtask
  task automatic run(input logic s, f, m, good, input int l, c);
    int i;
    logic fin, to;
    @(posedge clock_i);
    shutdown_mode_i <= s;
    freeze_i <= f;
    master_mode_i <= m;
    frame_len_i <= CNT_W'(l);
    frame_count_i <= CNT_W'(c);
    crc_word_i <= 32'hc0de0000 + 32'(l);
    dcrc <= good ? 32'hc0de0000 + 32'(l) : 32'h0;
    ctrl_word_i <= 32'h0000a500 + 32'(c);
    exp.delete();
    cpr_dev_model_i.words.delete();
    put(NOOP_WORD);
    put(SYNC_WORD);
    if (s)
    begin
      put(HDR_CMD_1);
      put(CMD_SHUTDOWN);
    end
    put(HDR_CMD_1);
    put(CMD_RESET_CRC_CMD);
    put(HDR_FLEN_1);
    put(32'(l - 1));
    if (m)
    begin
      put(HDR_CMD_1);
      put(CMD_SWITCH);
    end
    put(HDR_FAR_1);
    put(32'h0);
    put(HDR_CMD_1);
    put(CMD_WRITE_CONFIG_CMD);
    put(HDR_FDATA_0);
    put(HDR_TYPE2_BASE | 32'((c + 1) * l));
    for (i = 0; i < (c + 1) * l; i++)
      put(fdata_i + 32'(i));
    put(auto_crc_i);
    put(HDR_CMD_1);
    put(CMD_RESTORE);
    put(HDR_CMD_1);
    put(CMD_LAST_FRAME_CMD);
    if (f)
    begin
      put(HDR_CMD_1);
      put(CMD_WRITE_CONFIG_CMD);
      put(HDR_FAR_1);
      put(freeze_far_i);
      put(HDR_FDATA_52);
      for (i = 0; i < 52; i++)
        put(32'h0, 1'b1);
      put(auto_crc_i);
    end
    put(HDR_CMD_1);
    put(CMD_START);
    put(HDR_CTRL_1);
    put(32'h0000a500 + 32'(c));
    put(HDR_CRC_1);
    put(32'hc0de0000 + 32'(l));
    put(HDR_CMD_1);
    put(CMD_DESYNC);
    put(NOOP_WORD);
    put(NOOP_WORD);
    go_wait(fin, to);
    chk("finished", 32'h1, 32'(fin));
    chk("timeout", 32'(!good), 32'(to));
    chk("done", 32'(good), 32'(done_i));
    chk("words", 32'(exp.size()), 32'(cpr_dev_model_i.words.size()));
    for (i = 0; i < exp.size() && i < cpr_dev_model_i.words.size(); i++)
      if (!exp[i][32])
        chk("word", exp[i][31:0], cpr_dev_model_i.words[i]);
  endtask
  task automatic jtag_run();
    int s, j;
    logic fin, to, hit, ok;
    logic [1:0] q[$];
    @(posedge clock_i);
    jtag_shutdown_i <= 1'b1;
    cpr_dev_model_i.tapq.delete();
    go_wait(fin, to);
    q = cpr_dev_model_i.tapq;
    hit = 1'b0;
    for (s = 0; s + 29 <= q.size(); s++)
    begin
      ok = 1'b1;
      for (j = 0; j < 29; j++)
        if (q[s+j][1] !== ETMS[28-j] ||
            (j >= 10 && j < 16 && q[s+j][0] !== JTAG_SHUTDOWN_INSTR[j-10]))
          ok = 1'b0;
      hit = hit | ok;
    end
    chk("tap_seq", 32'h1, 32'(hit));
    chk("jtag_fin", 32'h1, 32'(fin));
    @(posedge clock_i);
    jtag_shutdown_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // tck free-running and unrelated in phase to the system clock
  initial
  begin
    tck_i = 1'b0;
    #3;
    forever #16 tck_i = ~tck_i;
  end
  // valid held until taken, one idle slot in four stalls the stream
  always @(posedge clock_i)
  begin
    gap <= gap + 2'h1;
    if (fdata_valid_i && fdata_ready_o)
      fdata_i <= fdata_i + 32'h1;
    fdata_valid_i <= (fdata_valid_i && !fdata_ready_o) || gap != 2'h3;
  end
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    fails = 0;
    compares = 0;
    cyc = 0;
    gap = 2'h0;
    {rst_n_i, tck_rst_n_i, go_i, shutdown_mode_i, jtag_shutdown_i} = 5'h0;
    {freeze_i, master_mode_i, fdata_valid_i} = 3'h0;
    ce_i = 1'b1;
    frame_len_i = '0;
    frame_count_i = '0;
    freeze_far_i = 32'h00042400;
    auto_crc_i = 32'h0000defc;
    {ctrl_word_i, crc_word_i, dcrc} = '0;
    fdata_i = 32'h00100000;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tck_rst_n_i <= 1'b1;
    run(1'b1, 1'b1, 1'b1, 1'b1, 3, 1);
    run(1'b0, 1'b0, 1'b0, 1'b1, 2, 2);
    run(1'b1, 1'b0, 1'b1, 1'b0, 4, 0);
    jtag_run();
    report_and_stop();
  end
endmodule // testbench
bind cpr_host cpr_host_props cpr_host_props_i (.*);
`default_nettype wire
